// >>> logic/irq_route.sv
/*
 * Peripheral interrupt routing and nested priority controller.
 * Each peripheral request (already the OR of its enabled flags) sets the
 * pending bit of its own line; software enables lines, sets and clears
 * pending bits and sets a two-bit priority per line over APB. The highest
 * priority enabled pending line is presented to the core.
 * Assumes peripheral requests and APB signals synchronous to mclk.
 */
// Overview of operation
// [RL1] 32 request lines, four priority levels each.
// [RL2] Each line driven by one peripheral only.
// [RL3] Peripheral flags set regardless of enable.
// [RL4] Enable-set write of one enables source.
// [RL5] Enable-clear write of one disables source.
// [RL6] Source request equals flag and enable.
// [RL7] Peripheral requests ORed into one line.
// [RL8] Request sets pending; software sets/clears pending.
// [RL9] Only enabled pending lines become active.
// [RL10] Writable priority field per line used.
// [RL11] Non-maskable output goes to core NMI.
// [RL12] Lines 0-6: fixed system peripherals order.
// [RL13] Lines 7-12: serial modules 0 to 5.
// [RL14] Lines 13-20: timer units 0 to 7.
// [RL15] Lines 21-24: ADC, comparator, DAC, touch.
// [RL16] Lines 25-31 tied inactive.
// [RL17] Equal priority: lowest line number wins.
`timescale 1ns/1ps
`default_nettype none

module irq_route
    import irq_route_pkg::*;
(
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [NUM_PERIPH-1:0]   periph_req,
    input  wire logic                    ext_nmi_req,
    output logic                         core_nmi,
    output logic                         core_irq,
    output logic      [4:0]              core_irq_line,
    output logic                         irq
);

    // Line enable, pending and priority state.
    logic [NUM_LINES-1:0]   line_en_reg;
    logic [NUM_LINES-1:0]   pend_reg;
    logic [PRIO_W-1:0]      prio_reg [NUM_LINES];
    logic [NUM_LINES-1:0]   line_req;
    logic [NUM_LINES-1:0]   cand;
    logic [5:0]             best_next;
    logic [PRIO_W-1:0]      best_prio;
    logic [1:0]             status_reg;
    logic [1:0]             mask_reg;
    logic                   irq_seen_reg;
    logic                   wr_en;
    logic                   rd_en;
    logic                   addr_ok;
    logic [31:0]            rdata_next;

    // Peripheral lines 0..24 map one to one, 25..31 are held low.
    assign line_req = {7'h00, periph_req}; // [RL2] [RL7] [RL12] [RL13] [RL14] [RL15] [RL16]

    // APB strobes; the slave answers with zero wait states.
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;

    // Line enable: set and clear views share one register.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            line_en_reg <= RST_ZERO;
        else if (wr_en && paddr == OFF_LINE_EN_SET)
            line_en_reg <= line_en_reg | pwdata; // [RL4]
        else if (wr_en && paddr == OFF_LINE_EN_CLR)
            line_en_reg <= line_en_reg & ~pwdata; // [RL5]
    end

    // Pending: hardware set wins over software clear.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            pend_reg <= RST_ZERO;
        else if (wr_en && paddr == OFF_PEND_SET)
            pend_reg <= pend_reg | pwdata | line_req; // [RL8]
        else if (wr_en && paddr == OFF_PEND_CLR)
            pend_reg <= (pend_reg & ~pwdata) | line_req; // [RL8]
        else
            pend_reg <= pend_reg | line_req; // [RL3] [RL6] [RL8]
    end

    // Priority fields, four lines per word, one byte per line.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LINES; gi++)
        begin : g_prio
            localparam logic [11:0] WOFF = OFF_PRIO_BASE + 12'((gi / 4) * 4);
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                    prio_reg[gi] <= '0;
                else if (wr_en && paddr == WOFF)
                    prio_reg[gi] <= pwdata[(gi % 4) * 8 +: PRIO_W]; // [RL10]
            end
        end
    endgenerate

    // Candidates are enabled pending lines.
    assign cand = pend_reg & line_en_reg; // [RL9]

    // Pick lowest priority value, ties to lowest line number.
    always_comb
    begin
        best_next = NO_ACTIVE;
        best_prio = '1;
        for (int i = NUM_LINES - 1; i >= 0; i--)
        begin
            if (cand[i] && (best_next == NO_ACTIVE || prio_reg[i] <= best_prio))
            begin
                best_next = 6'(i); // [RL1] [RL10] [RL17]
                best_prio = prio_reg[i];
            end
        end
    end

    // Registered request to the core and NMI pass-through.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            core_irq      <= 1'b0;
            core_irq_line <= 5'h00;
            core_nmi      <= 1'b0;
        end
        else
        begin
            core_irq      <= (best_next != NO_ACTIVE); // [RL9]
            core_irq_line <= best_next[4:0];
            core_nmi      <= ext_nmi_req; // [RL11]
        end
    end

    // Sticky status: bit0 core request rose, bit1 NMI seen; read clears.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_reg   <= 2'h0;
            irq_seen_reg <= 1'b0;
        end
        else
        begin
            irq_seen_reg <= core_irq;
            status_reg   <= ((rd_en && paddr == OFF_IRQ_STATUS) ? 2'h0
                             : status_reg)
                            | {ext_nmi_req, core_irq & ~irq_seen_reg};
        end
    end

    // Interrupt mask register.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            mask_reg <= 2'h0;
        else if (wr_en && paddr == OFF_IRQ_MASK)
            mask_reg <= pwdata[1:0];
    end

    // Level interrupt output.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(status_reg & mask_reg);
    end

    // Read mux and decode of mapped addresses.
    always_comb
    begin
        addr_ok    = 1'b1;
        rdata_next = RST_ZERO;
        case (paddr)
            OFF_LINE_EN_SET, OFF_LINE_EN_CLR: rdata_next = line_en_reg;
            OFF_PEND_SET, OFF_PEND_CLR:       rdata_next = pend_reg;
            OFF_ACTIVE:     rdata_next = {26'h0, best_next};
            OFF_IRQ_STATUS: rdata_next = {30'h0, status_reg};
            OFF_IRQ_MASK:   rdata_next = {30'h0, mask_reg};
            default:
            begin
                if (paddr >= OFF_PRIO_BASE && paddr < OFF_ACTIVE
                    && paddr[1:0] == 2'b00)
                begin
                    for (int k = 0; k < 4; k++)
                        rdata_next[k * 8 +: PRIO_W] =
                            prio_reg[5'((paddr - OFF_PRIO_BASE) + 12'(k))];
                end
                else
                    addr_ok = 1'b0;
            end
        endcase
    end

    // APB answer registers: ready in the access cycle, error if unmapped.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata  <= RST_ZERO;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            if (psel && !penable && !pwrite)
                prdata <= addr_ok ? rdata_next : RST_ZERO;
        end
    end

    // Checker helper: set when some candidate outranks the chosen line.
    logic outranked;
    always_comb
    begin
        outranked = 1'b0;
        for (int j = 0; j < NUM_LINES; j++)
        begin
            if (cand[j] && best_next != NO_ACTIVE
                && (prio_reg[j] < prio_reg[best_next[4:0]]
                    || (prio_reg[j] == prio_reg[best_next[4:0]]
                        && 6'(j) < best_next)))
                outranked = 1'b1;
        end
    end

    // Assertions.
    property p_req_sets_pend;
        @(posedge mclk) disable iff (!rst_n)
        periph_req[0] |=> pend_reg[0];
    endproperty
    a_req_sets_pend: assert property (p_req_sets_pend) // [RL8]
        else $error("Request did not set pending.");

    property p_high_lines_idle;
        @(posedge mclk) disable iff (!rst_n)
        !$past(wr_en) |-> (pend_reg[31:25] == $past(pend_reg[31:25]));
    endproperty
    a_high_lines_idle: assert property (p_high_lines_idle) // [RL16]
        else $error("Unused line pending changed by hardware.");

    property p_en_set;
        @(posedge mclk) disable iff (!rst_n)
        (wr_en && paddr == OFF_LINE_EN_SET) |=> ((line_en_reg & $past(pwdata))
                                                  == $past(pwdata));
    endproperty
    a_en_set: assert property (p_en_set) // [RL4]
        else $error("Enable set write failed.");

    property p_en_clr;
        @(posedge mclk) disable iff (!rst_n)
        (wr_en && paddr == OFF_LINE_EN_CLR) |=> ((line_en_reg & $past(pwdata))
                                                  == 32'h0000_0000);
    endproperty
    a_en_clr: assert property (p_en_clr) // [RL5]
        else $error("Enable clear write failed.");

    property p_irq_needs_enable;
        @(posedge mclk) disable iff (!rst_n)
        core_irq |-> $past(|(pend_reg & line_en_reg));
    endproperty
    a_irq_needs_enable: assert property (p_irq_needs_enable) // [RL9]
        else $error("Core request without enabled pending line.");

    property p_line_is_cand;
        @(posedge mclk) disable iff (!rst_n)
        core_irq |-> $past(cand[best_next[4:0]]);
    endproperty
    a_line_is_cand: assert property (p_line_is_cand) // [RL10]
        else $error("Chosen line is not a candidate.");

    property p_tie_low;
        @(posedge mclk) disable iff (!rst_n)
        (cand[0] && prio_reg[0] == 2'h0) |=> (core_irq_line == 5'h00);
    endproperty
    a_tie_low: assert property (p_tie_low) // [RL17]
        else $error("Lowest line did not win at top priority.");

    property p_nmi;
        @(posedge mclk) disable iff (!rst_n)
        ext_nmi_req |=> core_nmi;
    endproperty
    a_nmi: assert property (p_nmi) // [RL11]
        else $error("NMI not forwarded.");

    property p_nmi_drop;
        @(posedge mclk) disable iff (!rst_n)
        !ext_nmi_req |=> !core_nmi;
    endproperty
    a_nmi_drop: assert property (p_nmi_drop) // [RL11]
        else $error("NMI held after request dropped.");

    property p_best_line;
        @(posedge mclk) disable iff (!rst_n)
        core_irq |-> !$past(outranked);
    endproperty
    a_best_line: assert property (p_best_line) // [RL10] [RL17]
        else $error("A more urgent candidate was passed over.");

    property p_pend_set;
        @(posedge mclk) disable iff (!rst_n)
        (wr_en && paddr == OFF_PEND_SET) |=> ((pend_reg & $past(pwdata))
                                               == $past(pwdata));
    endproperty
    a_pend_set: assert property (p_pend_set) // [RL8]
        else $error("Pending set write failed.");

    property p_pend_clr;
        @(posedge mclk) disable iff (!rst_n)
        (wr_en && paddr == OFF_PEND_CLR)
            |=> ((pend_reg & $past(pwdata) & ~$past(line_req))
                 == 32'h0000_0000);
    endproperty
    a_pend_clr: assert property (p_pend_clr) // [RL8]
        else $error("Pending clear write failed.");

    c_irq: cover property (@(posedge mclk) disable iff (!rst_n)
        $rose(core_irq));
    c_nmi: cover property (@(posedge mclk) disable iff (!rst_n)
        $rose(core_nmi));
    c_int: cover property (@(posedge mclk) disable iff (!rst_n)
        $rose(irq));
    c_tie: cover property (@(posedge mclk) disable iff (!rst_n)
        cand[1] && cand[3] && core_irq_line == 5'h01);

endmodule // irq_route

`default_nettype wire

// >>> logic/irq_route_pkg.sv
/*
 * Constants for the peripheral interrupt routing block: register offsets,
 * line numbering, reset values and field widths.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
`default_nettype none

package irq_route_pkg;

    // Number of request lines and priority field width.
    localparam int NUM_LINES  = 32;
    localparam int PRIO_W     = 2;
    localparam int NUM_PERIPH = 25;

    // Line numbers of the peripheral groups.
    localparam int LINE_POWER_MANAGER   = 0;
    localparam int LINE_SYSTEM_CTRL     = 1;
    localparam int LINE_WATCHDOG        = 2;
    localparam int LINE_RTC             = 3;
    localparam int LINE_EXT_IRQ_UNIT    = 4;
    localparam int LINE_NVM_CTRL        = 5;
    localparam int LINE_EVENT_ROUTER    = 6;
    localparam int LINE_SERIAL_BASE     = 7;
    localparam int LINE_TIMER_BASE      = 13;
    localparam int LINE_ADC             = 21;
    localparam int LINE_ANALOG_COMP     = 22;
    localparam int LINE_DAC             = 23;
    localparam int LINE_TOUCH_CTRL      = 24;

    // Register byte offsets.
    localparam logic [11:0] OFF_LINE_EN_SET   = 12'h000;
    localparam logic [11:0] OFF_LINE_EN_CLR   = 12'h004;
    localparam logic [11:0] OFF_PEND_SET      = 12'h008;
    localparam logic [11:0] OFF_PEND_CLR      = 12'h00C;
    localparam logic [11:0] OFF_PRIO_BASE     = 12'h010;
    localparam logic [11:0] OFF_ACTIVE        = 12'h030;
    localparam logic [11:0] OFF_IRQ_STATUS    = 12'h034;
    localparam logic [11:0] OFF_IRQ_MASK      = 12'h038;

    // Reset values.
    localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
    localparam logic [5:0]  NO_ACTIVE   = 6'h20;

endpackage : irq_route_pkg

`default_nettype wire

// >>> verification/periph_model.sv
/*
 * Behavioural peripherals: one flag and one enable per line.
 * Assumes the bench pulses events, enables and flag clears on mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module periph_model
    import irq_route_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic [NUM_PERIPH-1:0] evt,
    input  wire logic [NUM_PERIPH-1:0] en_set,
    input  wire logic [NUM_PERIPH-1:0] en_clr,
    input  wire logic [NUM_PERIPH-1:0] flag_clr,
    output logic      [NUM_PERIPH-1:0] periph_req
);
    logic [NUM_PERIPH-1:0] flag_reg;
    logic [NUM_PERIPH-1:0] en_reg;

    // Flags latch their event whatever the enable says.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            flag_reg <= '0;
        else
            flag_reg <= (flag_reg & ~flag_clr) | evt;
    end

    // One enable state sits behind both set and clear ports.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            en_reg <= '0;
        else
            en_reg <= (en_reg | en_set) & ~en_clr;
    end

    // Each peripheral drives only its own line with its enabled flags.
    assign periph_req = flag_reg & en_reg;
endmodule // periph_model

`default_nettype wire

// >>> verification/peripheral_interrupt_routing_test.sv
/*
 * Register-level bench for the interrupt router over APB.
 * Assumes the zero-wait APB slave and registered outputs of irq_route.
 */
`timescale 1ns/1ps
`default_nettype none

module peripheral_interrupt_routing_test;
    import irq_route_pkg::*;
    logic                  mclk = 0, rst_n = 0;
    logic                  psel = 0, penable = 0, pwrite = 0;
    logic [11:0]           paddr = '0;
    logic [31:0]           pwdata = '0, prdata, q;
    logic                  pready, pslverr, e, ext_nmi_req = 0;
    logic                  core_nmi, core_irq, irq;
    logic [4:0]            core_irq_line;
    logic [NUM_PERIPH-1:0] periph_req, evt = '0, en_set = '0;
    logic [NUM_PERIPH-1:0] en_clr = '0, flag_clr = '0;
    int                    miscompares = 0, checked = 0;

    always #5 mclk = ~mclk;

    irq_route u_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periph_req(periph_req), .ext_nmi_req(ext_nmi_req),
        .core_nmi(core_nmi), .core_irq(core_irq),
        .core_irq_line(core_irq_line), .irq(irq));

    periph_model u_periph (.mclk(mclk), .rst_n(rst_n), .evt(evt),
        .en_set(en_set), .en_clr(en_clr), .flag_clr(flag_clr),
        .periph_req(periph_req));

    // Prints the counts and the verdict, then stops.
    task automatic results();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] s, x);
        checked++;
        if (s !== x)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // One APB transfer; held until pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 40);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        if (n >= 40)
        begin
            miscompares++;
            results();
        end
        @(posedge mclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(0, a, '0);
        chk("read", q, x);
    endtask

    // Event then flag clear: a one-cycle request from the peripheral.
    task automatic fire(input logic [NUM_PERIPH-1:0] m);
        evt <= m;
        @(posedge mclk);
        evt <= '0;
        flag_clr <= m;
        @(posedge mclk);
        flag_clr <= '0;
    endtask

    initial
    begin
        tick(12);
        rst_n <= 1;
        @(posedge mclk);
        rd(OFF_LINE_EN_SET, RST_ZERO);
        rd(OFF_PEND_CLR, RST_ZERO);
        rd(OFF_ACTIVE, 32'(NO_ACTIVE));
        apb(0, 12'h03C, 32'h0000_0000);
        chk("slverr", 32'(e), 1);
        chk("unmapped", q, 0);
        apb(1, OFF_LINE_EN_SET, 32'h0000_000A);
        apb(1, OFF_LINE_EN_SET, 32'h0000_0000);
        rd(OFF_LINE_EN_CLR, 32'h0000_000A);
        apb(1, OFF_LINE_EN_CLR, 32'h0000_0002);
        rd(OFF_LINE_EN_SET, 32'h0000_0008);
        // A flag held while disabled requests only once enabled.
        evt <= 25'h000_0020;
        @(posedge mclk);
        evt <= '0;
        tick(3);
        rd(OFF_PEND_CLR, 0);
        en_set <= '1;
        @(posedge mclk);
        en_set <= '0;
        tick(3);
        rd(OFF_PEND_CLR, 32'h0000_0020);
        flag_clr <= 25'h000_0020;
        @(posedge mclk);
        flag_clr <= '0;
        apb(1, OFF_PEND_CLR, 32'hFFFF_FFFF);
        rd(OFF_PEND_SET, 0);
        // Each peripheral sets only its own line; lines 25-31 stay idle.
        for (int i = 0; i < NUM_PERIPH; i++)
        begin
            fire(25'(1) << i);
            tick(2);
            rd(OFF_PEND_CLR, 32'(1) << i);
            apb(1, OFF_PEND_CLR, 32'hFFFF_FFFF);
        end
        rd(OFF_IRQ_STATUS, 32'h0000_0001);
        apb(1, OFF_LINE_EN_SET, 32'h0000_0002);
        apb(1, OFF_PEND_SET, 32'h0000_000A);
        tick(2);
        chk("core_irq", 32'(core_irq), 1);
        chk("irq_line", 32'(core_irq_line), 1);
        rd(OFF_ACTIVE, 1);
        apb(1, OFF_PRIO_BASE, 32'h0000_0300);
        rd(OFF_PRIO_BASE, 32'h0000_0300);
        // The last priority word holds line 31 in its top byte.
        apb(1, OFF_PRIO_BASE + 12'h01C, 32'h0300_0000);
        rd(OFF_PRIO_BASE + 12'h01C, 32'h0300_0000);
        tick(1);
        chk("irq_line", 32'(core_irq_line), 3);
        apb(1, OFF_LINE_EN_CLR, 32'h0000_0008);
        tick(2);
        chk("irq_line", 32'(core_irq_line), 1);
        apb(1, OFF_LINE_EN_CLR, 32'h0000_0002);
        tick(2);
        chk("core_irq", 32'(core_irq), 0);
        // Status bit 0 is still set from the pending write, but masked.
        apb(1, OFF_IRQ_MASK, 32'h0000_0002);
        tick(2);
        chk("irq", 32'(irq), 0);
        ext_nmi_req <= 1;
        tick(3);
        chk("core_nmi", 32'(core_nmi), 1);
        chk("irq", 32'(irq), 1);
        ext_nmi_req <= 0;
        tick(2);
        chk("core_nmi", 32'(core_nmi), 0);
        rd(OFF_IRQ_STATUS, 32'h0000_0003);
        tick(2);
        chk("irq", 32'(irq), 0);
        results();
    end
endmodule // peripheral_interrupt_routing_test

`default_nettype wire
